/* logic/rtcs_pkg.sv */
// Constants, types and divisor table for the run-time clock selector
package rtcs_pkg;

  // ==========================================================================
  // Register map
  localparam logic [11:0] ADDR_SETTINGS = 12'h000;
  localparam int          SET_W         = 8;
  localparam int          APB_AW        = 12;
  localparam int          APB_DW        = 32;
  localparam logic [31:0] PRDATA_ZERO   = 32'h0000_0000;

  // ==========================================================================
  // Field layout of clock_speed_settings
  localparam int BIT_PLL_OFF = 7;
  localparam int BIT_OSC_OFF = 6;
  localparam int SRC_HI      = 5;
  localparam int SRC_LO      = 4;
  localparam int DIV_HI      = 3;
  localparam int DIV_LO      = 0;

  // Reset value: multiplier on, oscillator on, oscillator source, divide by 1
  localparam logic [7:0] SETTINGS_RST = 8'h10;

  // ==========================================================================
  // Source and divisor codes
  localparam logic [1:0] SRC_PLL   = 2'h0;
  localparam logic [1:0] SRC_OSC   = 2'h1;
  localparam logic [1:0] SRC_RT    = 2'h2;
  localparam logic [1:0] SRC_STOP  = 2'h3;
  localparam logic [3:0] CDIV_ONE  = 4'h0;
  localparam logic [3:0] CDIV_STOP = 4'hF;
  localparam int         DIVV_W    = 8;
  localparam logic [7:0] DIVV_NONE = 8'h00;

  // Fuse field that picks the multiplier wake-up delay
  localparam logic [1:0] WAKEUP_DELAY_PERIOD_SEL0 = 2'h0;
  localparam logic [1:0] WAKEUP_DELAY_PERIOD_SEL1 = 2'h1;
  localparam logic [1:0] WAKEUP_DELAY_PERIOD_SEL2 = 2'h2;
  localparam logic [1:0] WAKEUP_DELAY_PERIOD_SEL3 = 2'h3;

  // ==========================================================================
  // Switch sequencer states
  typedef enum logic [1:0] {
    RTCS_RUN      = 2'b00,
    RTCS_WAIT_OLD = 2'b01,
    RTCS_WAIT_NEW = 2'b10
  } rtcs_sw_t;

  // Divisor for each code; zero means no core clock at all
  function automatic logic [7:0] rtcs_divisor(input logic [3:0] code);
    logic [7:0] v;
    v = DIVV_NONE;
    unique case (code)
      4'h0: v = 8'h01;
      4'h1: v = 8'h02;
      4'h2: v = 8'h03;
      4'h3: v = 8'h04;
      4'h4: v = 8'h05;
      4'h5: v = 8'h06;
      4'h6: v = 8'h08;
      4'h7: v = 8'h0A;
      4'h8: v = 8'h0C;
      4'h9: v = 8'h10;
      4'hA: v = 8'h18;
      4'hB: v = 8'h20;
      4'hC: v = 8'h30;
      4'hD: v = 8'h40;
      4'hE: v = 8'h80;
      4'hF: v = DIVV_NONE;
    endcase
    return v;
  endfunction

endpackage

/* logic/rtcs_clk_div.sv */
// Tick divider that forms the core clock enable from system clock ticks
`timescale 1ns/1ps
module rtcs_clk_div
  import rtcs_pkg::*;
#(
  parameter int W = DIVV_W
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic         tick_i,
  input  wire logic         clr_i,
  input  wire logic [W-1:0] div_i,
  output logic              wrap_o,
  output logic              tick_o
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } rtcs_div_st_t;

  rtcs_div_st_t q;
  rtcs_div_st_t d;
  logic         last;

  // A zero divisor holds the counter, so the core clock stops cleanly
  assign last   = (div_i != '0) && (q.cnt >= div_i - W'(1));
  assign wrap_o = tick_i && !clr_i && last;
  assign tick_o = q.tick;

  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (clr_i) begin
      d.cnt = '0;
    end else if (tick_i && (div_i != '0)) begin
      if (last) begin
        d.cnt  = '0;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

/* logic/rtcs_top.sv */
// Run-time clock selector: settings register, source select, divider, wake-up
`timescale 1ns/1ps
// What this block does
// - Settings register is read-only; only the speed instruction port changes it.
// - Multiplier runs while its control bit is 0, powered down at 1.
// - Restarted multiplier output is unused until the fuse-selected wake-up delay elapses.
// - Two-bit select picks multiplier, oscillator, real-time source, or stopped clock.
// - Four-bit code divides the system clock by 1 through 128 for core clock.
// - Divisor code 1111 stops the core clock entirely.
module rtcs_top
  import rtcs_pkg::*;
#(
  parameter int unsigned WAKEUP_DELAY_PERIOD_CYC0 = 1024,
  parameter int unsigned WAKEUP_DELAY_PERIOD_CYC1 = 2048,
  parameter int unsigned WAKEUP_DELAY_PERIOD_CYC2 = 4096,
  parameter int unsigned WAKEUP_DELAY_PERIOD_CYC3 = 8192,
  parameter int          WK_W      = 16
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic [APB_AW-1:0] paddr_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [APB_DW-1:0] pwdata_i,
  output logic      [APB_DW-1:0] prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              speed_exec_i,
  input  wire logic [SET_W-1:0]  speed_val_i,
  input  wire logic [1:0]        fuse_wakeup_delay_period_sel_i,
  input  wire logic              pll_tick_i,
  input  wire logic              osc_tick_i,
  input  wire logic              rt_tick_i,
  output logic                   pll_pwr_en_o,
  output logic                   pll_ready_o,
  output logic                   osc_en_o,
  output logic                   sys_tick_o,
  output logic                   core_tick_o,
  output logic                   switch_busy_o
);

  // ==========================================================================
  // Reset synchroniser
  logic rst_meta_q;
  logic rst_sync_n;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // ==========================================================================
  // State
  typedef struct packed {
    logic [SET_W-1:0]  settings;
    logic [1:0]        src_act;
    logic [3:0]        div_act;
    rtcs_sw_t          st;
    logic [WK_W-1:0]   wake_cnt;
    logic              pll_ready;
    logic              sys_tick;
    logic [APB_DW-1:0] prdata;
    logic              pslverr;
  } rtcs_st_t;

  localparam rtcs_st_t ST_RST = '{
    settings:  SETTINGS_RST,
    src_act:   SETTINGS_RST[SRC_HI:SRC_LO],
    div_act:   SETTINGS_RST[DIV_HI:DIV_LO],
    st:        RTCS_RUN,
    wake_cnt:  '0,
    pll_ready: 1'b0,
    sys_tick:  1'b0,
    prdata:    PRDATA_ZERO,
    pslverr:   1'b0
  };

  rtcs_st_t q;
  rtcs_st_t d;

  // ==========================================================================
  // Source gating and selection
  logic            pll_off;
  logic            osc_off;
  logic [1:0]      src_tgt;
  logic [3:0]      div_tgt;
  logic            pll_live;
  logic            osc_live;
  logic            old_tick;
  logic            new_tick;
  logic            old_live;
  logic            sys_tick;
  logic            div_wrap;
  logic            div_clr;
  logic [WK_W-1:0] wakeup_delay_period_cyc;
  logic            apb_setup;
  logic            change_req;

  assign pll_off  = q.settings[BIT_PLL_OFF];
  assign osc_off  = q.settings[BIT_OSC_OFF];
  assign src_tgt  = q.settings[SRC_HI:SRC_LO];
  assign div_tgt  = q.settings[DIV_HI:DIV_LO];
  assign pll_live = !pll_off && q.pll_ready;
  assign osc_live = !osc_off;

  function automatic logic src_tick(input logic [1:0] sel, input logic p_ok, input logic o_ok,
                                    input logic p_t, input logic o_t, input logic r_t);
    logic t;
    t = 1'b0;
    unique case (sel)
      SRC_PLL:  t = p_t && p_ok;
      SRC_OSC:  t = o_t && o_ok;
      SRC_RT:   t = r_t;
      SRC_STOP: t = 1'b0;
    endcase
    return t;
  endfunction

  function automatic logic src_alive(input logic [1:0] sel, input logic p_ok, input logic o_ok);
    logic a;
    a = 1'b0;
    unique case (sel)
      SRC_PLL:  a = p_ok;
      SRC_OSC:  a = o_ok;
      SRC_RT:   a = 1'b1;
      SRC_STOP: a = 1'b0;
    endcase
    return a;
  endfunction

  assign old_tick   = src_tick(q.src_act, pll_live, osc_live, pll_tick_i, osc_tick_i, rt_tick_i);
  assign new_tick   = src_tick(src_tgt, pll_live, osc_live, pll_tick_i, osc_tick_i, rt_tick_i);
  // A dead old clock can never reach a period end, so it is let go at once
  assign old_live   = src_alive(q.src_act, pll_live, osc_live) && (q.div_act != CDIV_STOP);
  assign sys_tick   = old_tick && (q.st != RTCS_WAIT_NEW);
  assign div_clr    = (q.st == RTCS_WAIT_NEW);
  assign change_req = (src_tgt != q.src_act) || (div_tgt != q.div_act);
  assign apb_setup  = psel_i && !penable_i;

  always_comb begin
    wakeup_delay_period_cyc = WK_W'(WAKEUP_DELAY_PERIOD_CYC0);
    unique case (fuse_wakeup_delay_period_sel_i)
      WAKEUP_DELAY_PERIOD_SEL0: wakeup_delay_period_cyc = WK_W'(WAKEUP_DELAY_PERIOD_CYC0);
      WAKEUP_DELAY_PERIOD_SEL1: wakeup_delay_period_cyc = WK_W'(WAKEUP_DELAY_PERIOD_CYC1);
      WAKEUP_DELAY_PERIOD_SEL2: wakeup_delay_period_cyc = WK_W'(WAKEUP_DELAY_PERIOD_CYC2);
      WAKEUP_DELAY_PERIOD_SEL3: wakeup_delay_period_cyc = WK_W'(WAKEUP_DELAY_PERIOD_CYC3);
    endcase
  end

  // ==========================================================================
  // Core clock divider
  rtcs_clk_div #(
    .W (DIVV_W)
  ) u_div (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_sync_n),
    .tick_i  (sys_tick),
    .clr_i   (div_clr),
    .div_i   (rtcs_divisor(q.div_act)),
    .wrap_o  (div_wrap),
    .tick_o  (core_tick_o)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    d          = q;
    d.sys_tick = sys_tick;

    // Bus writes never reach the settings; only the instruction port loads them
    if (speed_exec_i) begin
      d.settings = speed_val_i;
    end

    // Wake-up counter preloads while the multiplier is off
    if (pll_off) begin
      d.pll_ready = 1'b0;
      d.wake_cnt  = wakeup_delay_period_cyc;
    end else if (q.wake_cnt != '0) begin
      d.pll_ready = 1'b0;
      d.wake_cnt  = q.wake_cnt - WK_W'(1);
    end else begin
      d.pll_ready = 1'b1;
    end

    unique case (q.st)
      RTCS_RUN: begin
        if (change_req) begin
          d.st = old_live ? RTCS_WAIT_OLD : RTCS_WAIT_NEW;
        end
      end
      RTCS_WAIT_OLD: begin
        if (div_wrap || !old_live) begin
          d.st = RTCS_WAIT_NEW;
        end
      end
      RTCS_WAIT_NEW: begin
        if (new_tick || !src_alive(src_tgt, pll_live, osc_live) || (div_tgt == CDIV_STOP)) begin
          d.src_act = src_tgt;
          d.div_act = div_tgt;
          d.st      = RTCS_RUN;
        end
      end
    endcase

    // Answer is latched in the setup phase so the access phase reads a flop
    if (apb_setup) begin
      d.pslverr = (paddr_i != ADDR_SETTINGS);
      if (!pwrite_i && (paddr_i == ADDR_SETTINGS)) begin
        d.prdata = {{(APB_DW-SET_W){1'b0}}, q.settings};
      end else begin
        d.prdata = PRDATA_ZERO;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata_o      = q.prdata;
  assign pslverr_o     = q.pslverr;
  assign pready_o      = psel_i && penable_i;
  assign pll_pwr_en_o  = !pll_off;
  assign pll_ready_o   = q.pll_ready;
  assign osc_en_o      = !osc_off;
  assign sys_tick_o    = q.sys_tick;
  assign switch_busy_o = (q.st != RTCS_RUN);

  // ==========================================================================
  // Checks
  ro_write_a: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
    (psel_i && penable_i && pwrite_i && !speed_exec_i) |=> $stable(q.settings))
    else $error("bus write changed clock settings");

  speed_load_a: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
    speed_exec_i |=> (q.settings == $past(speed_val_i)))
    else $error("speed instruction did not load settings");

  // Ready is a flop, so it trails the power bit by one cycle
  pll_power_a: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
    $rose(q.settings[BIT_PLL_OFF]) |-> !pll_pwr_en_o ##1 !pll_ready_o)
    else $error("multiplier still powered or ready after power down");

  pll_wake_a: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
    ($fell(q.settings[BIT_PLL_OFF]) && (q.wake_cnt != '0)) |-> !pll_ready_o [*2])
    else $error("multiplier ready before wake-up delay");

  osc_block_a: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
    (osc_off && (q.src_act == SRC_OSC)) |=> !sys_tick_o)
    else $error("oscillator tick passed while oscillator off");

  src_stop_a: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
    (q.src_act == SRC_STOP) |=> !sys_tick_o)
    else $error("system tick while source stopped");

  src_rt_a: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
    ((q.st == RTCS_RUN) && (q.src_act == SRC_RT) && rt_tick_i) |=> sys_tick_o)
    else $error("real-time tick not forwarded");

  div_one_a: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
    ((q.st == RTCS_RUN) && (q.div_act == CDIV_ONE) && sys_tick) |=> core_tick_o)
    else $error("divide by one missed a core tick");

  div_stop_a: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
    (q.div_act == CDIV_STOP) [*2] |-> !core_tick_o)
    else $error("core tick with divisor code stop");

  switch_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
    ((q.st == RTCS_WAIT_OLD) && !div_wrap && old_live) |=> ($stable(q.src_act) && $stable(q.div_act)))
    else $error("clock switched before old period ended");

  apb_read_a: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
    (apb_setup && !pwrite_i && (paddr_i == ADDR_SETTINGS)) |=> (prdata_o[SET_W-1:0] == $past(q.settings)))
    else $error("settings read returned wrong value");

endmodule

/* testbench/rtcs_far_model.sv */
// Far-side model: speed instruction issuer and free-running clock sources
`timescale 1ns/1ps
module rtcs_far_model #(
  parameter int P_PLL = 3,
  parameter int P_OSC = 2,
  parameter int P_RT  = 5
) (
  input  wire logic       mclk_i,
  input  wire logic       pll_pwr_en_i,
  input  wire logic       osc_en_i,
  output logic            pll_tick_o,
  output logic            osc_tick_o,
  output logic            rt_tick_o,
  output logic            speed_exec_o,
  output logic [7:0]      speed_val_o
);
  // ==========================================================================
  // Sources
  int cnt_q = 0;

  always @(posedge mclk_i) begin
    cnt_q <= cnt_q + 1;
  end

  // A powered-down multiplier or stopped oscillator gives no edges at all
  assign pll_tick_o = pll_pwr_en_i && (cnt_q % P_PLL == 0);
  assign osc_tick_o = osc_en_i && (cnt_q % P_OSC == 0);
  assign rt_tick_o  = (cnt_q % P_RT == 0);

  // ==========================================================================
  // Speed instruction, the only way the settings change
  initial begin
    speed_exec_o = 1'b0;
    speed_val_o  = 8'h00;
  end

  task automatic exec(input logic [7:0] v);
    @(posedge mclk_i);
    speed_exec_o <= 1'b1;
    speed_val_o  <= v;
    @(posedge mclk_i);
    speed_exec_o <= 1'b0;
    // Return where the freshly loaded settings have settled
    @(negedge mclk_i);
  endtask
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the run-time clock selector
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, a, e); end end
module testbench
  import rtcs_pkg::*;
;
  logic        mclk_i, rst_n_i, psel, penable, pwrite, pready, pslverr, exec, err;
  logic        pt, ot, rt, pll_pwr_en, pll_ready, osc_en, sys_tick, core_tick, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  val;
  logic [1:0]  fuse;
  int          fails, comparisons, cyc, gap, min_gap, n, k;
  int          per[3] = '{3, 2, 5};
  int          dv[15] = '{1, 2, 3, 4, 5, 6, 8, 10, 12, 16, 24, 32, 48, 64, 128};
  localparam int WK0 = 4;
  localparam int WK1 = 6;
  localparam int WK2 = 8;
  localparam int WK3 = 10;
  int          wk[4] = '{WK0, WK1, WK2, WK3};

  rtcs_top #(.WAKEUP_DELAY_PERIOD_CYC0(WK0), .WAKEUP_DELAY_PERIOD_CYC1(WK1), .WAKEUP_DELAY_PERIOD_CYC2(WK2), .WAKEUP_DELAY_PERIOD_CYC3(WK3)) dut_u (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .speed_exec_i(exec), .speed_val_i(val), .fuse_wakeup_delay_period_sel_i(fuse), .pll_tick_i(pt), .osc_tick_i(ot),
    .rt_tick_i(rt), .pll_pwr_en_o(pll_pwr_en), .pll_ready_o(pll_ready), .osc_en_o(osc_en),
    .sys_tick_o(sys_tick), .core_tick_o(core_tick), .switch_busy_o(busy));

  rtcs_far_model far_u (
    .mclk_i(mclk_i), .pll_pwr_en_i(pll_pwr_en), .osc_en_i(osc_en), .pll_tick_o(pt), .osc_tick_o(ot),
    .rt_tick_o(rt), .speed_exec_o(exec), .speed_val_o(val));

  // ==========================================================================
  // Clock, timeout and core period monitor
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cyc++;
    gap++;
    if (core_tick === 1'b1) begin
      if (gap < min_gap) min_gap = gap;
      gap = 0;
    end
    if (cyc == 30000) begin
      fails++;
      end_sim();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    @(posedge mclk_i);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge mclk_i);
    penable <= 1'b1;
    // Waits for pready; only the bench timeout ends a hung wait
    do begin
      @(posedge mclk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Cycles until the next sys or core tick; partial first interval, so call twice
  task automatic wt(input logic core, output int c);
    c = 0;
    do begin
      @(posedge mclk_i);
      c++;
    end while (((core ? core_tick : sys_tick) !== 1'b1) && c < 2000);
  endtask

  task automatic cnt(input logic core, output int c);
    c = 0;
    repeat (200) begin
      @(posedge mclk_i);
      if ((core ? core_tick : sys_tick) === 1'b1) c++;
    end
  endtask

  task automatic idle();
    int t;
    repeat (3) @(posedge mclk_i);
    t = 0;
    while (busy !== 1'b0 && t < 2000) begin
      @(posedge mclk_i);
      t++;
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    {rst_n_i, psel, penable, pwrite, paddr, pwdata, fuse} = '0;
    {fails, comparisons, cyc, gap} = '0;
    min_gap = 1000;
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    apb(ADDR_SETTINGS, 1'b0, 32'h0);
    `CHK(rd, {24'h0, SETTINGS_RST})
    apb(ADDR_SETTINGS, 1'b1, 32'hFFFF_FFFF);
    `CHK(err, 1'b0)
    apb(ADDR_SETTINGS, 1'b0, 32'h0);
    `CHK(rd, {24'h0, SETTINGS_RST})
    apb(12'h004, 1'b0, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, PRDATA_ZERO)
    // Every live source, divide by one, so core period equals source period
    for (int s = 0; s < 3; s++) begin
      far_u.exec({2'b00, 2'(s), CDIV_ONE});
      idle();
      wt(1'b0, n);
      wt(1'b0, n);
      `CHK(n, per[s])
      wt(1'b1, n);
      wt(1'b1, n);
      `CHK(n, per[s])
      apb(ADDR_SETTINGS, 1'b0, 32'h0);
      `CHK(rd[7:0], {2'b00, 2'(s), CDIV_ONE})
    end
    far_u.exec({2'b00, SRC_STOP, CDIV_ONE});
    idle();
    cnt(1'b0, k);
    `CHK(k, 0)
    far_u.exec(8'h50);
    `CHK(osc_en, 1'b0)
    idle();
    cnt(1'b0, k);
    `CHK(k, 0)
    // Full divisor table on the oscillator, period 2
    for (int c = 0; c < 15; c++) begin
      far_u.exec({2'b00, SRC_OSC, 4'(c)});
      `CHK(osc_en, 1'b1)
      idle();
      `CHK(busy, 1'b0)
      wt(1'b1, n);
      wt(1'b1, n);
      `CHK(n, dv[c] * 2)
    end
    far_u.exec({2'b00, SRC_OSC, CDIV_STOP});
    idle();
    cnt(1'b1, k);
    `CHK(k, 0)
    // Multiplier off and back on for every fuse wake setting
    for (int f = 0; f < 4; f++) begin
      fuse <= 2'(f);
      far_u.exec(8'h80);
      repeat (2) @(posedge mclk_i);
      `CHK(pll_pwr_en, 1'b0)
      `CHK(pll_ready, 1'b0)
      far_u.exec({2'b00, SRC_PLL, CDIV_ONE});
      `CHK(pll_pwr_en, 1'b1)
      n = 0;
      k = 0;
      while (pll_ready !== 1'b1 && n < 100) begin
        @(posedge mclk_i);
        n++;
        if (sys_tick === 1'b1) k++;
      end
      `CHK(k, 0)
      `CHK((n >= wk[f] - 1 && n <= wk[f] + 3), 1'b1)
      idle();
      wt(1'b0, n);
      wt(1'b0, n);
      `CHK(n, per[0])
    end
    // No runt core period across all switches seen so far
    `CHK((min_gap >= 2), 1'b1)
    end_sim();
  end
endmodule
